/* File: core/rlvs_top.sv */
// Reset source gathering and low-voltage supervision with APB registers
// ==========================================================
// Overview of operation
// - Illegal opcode forces system reset through reset vector.
// - Illegal address access forces system reset through reset vector.
// - Wake-up interval elapsing sets its flag and resets the system.
// - Watchdog expiry with watchdog enabled resets the system.
// - Temperature crossing with restart enabled resets the system.
// - Software interrupt goes through vector below reset, no flag or enable.
// - Wake from deepest stop uses reset vector over any interrupt vector.
// - Detector active only when enabled; select bit picks high or low trip.
// - Detection turns off in stop unless its stop keepalive is set; detector_on still shows the enable.
// - Enable plus keepalive both set refuses deepest stop entry.
// - After power-on, hold reset until supply exceeds selected trip.
// - Power-on sets power-on and undervolt cause bits.
// - Reset-enabled undervolt resets and holds until supply recovers.
// - Interrupt mode undervolt sets flag and requests interrupt instead.
// - Warning flag sets when supply below selected warning level.
// - Warning ack clears flag, ignored while supply still low.
// - Warning flag never requests an interrupt; polling only.
// - Cause register seven read-only flags; write clears watchdog.
// - Other resets set bits of active sources, clear the rest.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rlvs_top (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire rlvs_pkg::rlvs_cmp_t cmp_in,
	input  wire rlvs_pkg::rlvs_evt_t evt_in,
	output logic                    sys_reset,
	output logic                    irq_req,
	output logic      [15:0]        vector_addr,
	output logic                    stop_active,
	output logic                    deep_stop_active,
	output logic                    detector_on,
	output logic                    trip_level_high,
	output logic                    warn_level_high,
	output logic                    watchdog_clear,
	output logic                    temp_restart_enable
);
	import rlvs_pkg::*;

	typedef struct packed {
		rlvs_cmp_t  s1;
		rlvs_cmp_t  s2;
		rlvs_mode_t mode;
		logic [7:0] cause;
		logic [7:0] pmc1;
		logic [7:0] pmc3;
		logic [7:0] sysc;
		logic [5:0] wake_ival;
		logic [5:0] wake_cnt;
		logic       wake_flag;
		logic [31:0] prdata;
		logic       pready;
		logic       pslverr;
		logic       sys_reset;
		logic       irq;
		logic [15:0] vec;
		logic       wdclr;
	} rlvs_state_t;

	rlvs_state_t st_q;
	rlvs_state_t st_d;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rd_mux(input rlvs_state_t s,
	                                       input logic [11:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			ADDR_CAUSE: r = {24'h000000, s.cause};
			ADDR_PMC1:  r = {24'h000000, s.pmc1 & ~(8'h01 << P1_UVACK)};
			ADDR_PMC3:  r = {24'h000000, s.pmc3 & ~(8'h01 << P3_WACK)};
			ADDR_SYSC:  r = {24'h000000, s.sysc};
			ADDR_WAKE:  r = {25'h0000000, s.wake_flag, s.wake_ival};
			default:    r = 32'h0000_0000;
		endcase
		return r;
	endfunction : rd_mux

	function automatic logic mapped(input logic [11:0] a);
		return (a == ADDR_CAUSE) || (a == ADDR_PMC1) || (a == ADDR_PMC3) ||
		       (a == ADDR_SYSC) || (a == ADDR_WAKE);
	endfunction : mapped

	// ==========================================================
	// Decode and supervision terms
	logic acc;
	logic wr;
	logic in_stop;
	logic det_active;
	logic supply_ok;
	logic warn_ok;
	logic uv_low;
	logic src_op;
	logic src_ad;
	logic src_wdg;
	logic src_pwu;
	logic src_pin;
	logic src_tmp;
	logic src_uvr;
	logic src_dwk;
	logic uv_set;
	logic any_src;
	logic wake_hit;

	// ==========================================================
	// Next-state logic
	always_comb begin
		st_d = st_q;
		// Commit on the first access edge; the registered pready ends it
		acc  = psel && penable && !st_q.pready;
		wr   = acc && pwrite;
		st_d.pready  = acc;
		st_d.pslverr = acc && !mapped(paddr);
		st_d.wdclr   = 1'b0;
		st_d.s1 = cmp_in;
		st_d.s2 = st_q.s1;

		in_stop = st_q.sysc[S_STOP] || st_q.sysc[S_DEEP];
		det_active = st_q.pmc1[P1_UVDE] &&
		             (!in_stop || st_q.pmc1[P1_UVSE]);
		supply_ok = st_q.pmc3[P3_UVV] ? st_q.s2.above_hi : st_q.s2.above_lo;
		warn_ok   = st_q.pmc3[P3_WV]  ? st_q.s2.warn_hi  : st_q.s2.warn_lo;
		uv_low    = det_active && !supply_ok;
		// Interrupt mode only while reset enable is clear
		uv_set    = uv_low && st_q.pmc1[P1_UVIE] && !st_q.pmc1[P1_UVRE];

		// ==========================================================
		// Wake-up interval counter, one step per wake tick
		wake_hit = 1'b0;
		if (st_q.wake_ival != WAKE_OFF && evt_in.wake_tick) begin
			if (st_q.wake_cnt + 6'h01 >= st_q.wake_ival) begin
				wake_hit = 1'b1;
				st_d.wake_cnt = 6'h00;
			end else begin
				st_d.wake_cnt = st_q.wake_cnt + 6'h01;
			end
		end

		// ==========================================================
		// Reset sources
		// illegal opcode
		src_op  = evt_in.ill_op;
		src_ad  = evt_in.ill_addr;
		src_wdg = evt_in.wdg_expire && st_q.sysc[S_WDGE];
		src_pwu = wake_hit;
		src_pin = evt_in.ext_pin;
		src_tmp = st_q.s2.temp_cross && st_q.sysc[S_TRE];
		src_uvr = uv_low && st_q.pmc1[P1_UVRE];
		// wake from deepest stop
		// The core cannot fetch an interrupt vector there, so it restarts
		src_dwk = st_q.sysc[S_DEEP] && (evt_in.swi || uv_set);
		any_src = src_op || src_ad || src_wdg || src_pwu ||
		          src_pin || src_tmp || src_dwk;

		// ==========================================================
		// Reset sequencer
		st_d.sys_reset = 1'b0;
		unique case (st_q.mode)
			RLVS_HOLD: begin
				// hold until supply above selected trip
				st_d.sys_reset = 1'b1;
				st_d.vec = VEC_RESET;
				if (st_q.s2.por_ok && supply_ok)
					st_d.mode = RLVS_RUN;
			end
			RLVS_RESET: begin
				st_d.sys_reset = 1'b1;
				st_d.mode = RLVS_RUN;
			end
			RLVS_RUN: begin
				st_d.irq = 1'b0;
				if (src_uvr) begin
					st_d.cause = 8'h00;
					st_d.cause[C_POR] = 1'b1;
					st_d.cause[C_UV]  = 1'b1;
					st_d.pmc1 = PMC1_RST;
					st_d.pmc3 = 8'h00;
					st_d.sysc = 8'h00;
					st_d.wake_ival = WAKE_OFF;
					st_d.vec = VEC_RESET;
					st_d.sys_reset = 1'b1;
					st_d.mode = RLVS_HOLD;
				end else if (any_src) begin
					st_d.cause = 8'h00;
					st_d.cause[C_PIN]  = src_pin;
					st_d.cause[C_WDG]  = src_wdg;
					st_d.cause[C_ILOP] = src_op;
					st_d.cause[C_ILAD] = src_ad;
					st_d.cause[C_PWU]  = src_pwu;
					st_d.wake_flag = src_pwu;
					st_d.pmc1 = PMC1_RST;
					st_d.pmc3 = 8'h00;
					st_d.sysc = 8'h00;
					st_d.wake_ival = WAKE_OFF;
					st_d.wake_cnt = 6'h00;
					// deepest stop wake through reset vector
					st_d.vec = VEC_RESET;
					st_d.sys_reset = 1'b1;
					st_d.mode = RLVS_RESET;
				end else begin
					if (wr && paddr == ADDR_CAUSE)
						st_d.wdclr = 1'b1;
					if (wr && paddr == ADDR_PMC1) begin
						st_d.pmc1[P1_UVIE:P1_UVDE] = pwdata[P1_UVIE:P1_UVDE];
						if (pwdata[P1_UVACK])
							st_d.pmc1[P1_UVIF] = 1'b0;
					end
					if (wr && paddr == ADDR_PMC3) begin
						st_d.pmc3[P3_UVV] = pwdata[P3_UVV];
						st_d.pmc3[P3_WV]  = pwdata[P3_WV];
						if (pwdata[P3_WACK] && warn_ok)
							st_d.pmc3[P3_WF] = 1'b0;
					end
					if (wr && paddr == ADDR_SYSC) begin
						st_d.sysc[S_WDGE] = pwdata[S_WDGE];
						st_d.sysc[S_TRE]  = pwdata[S_TRE];
						st_d.sysc[S_STOP] = pwdata[S_STOP];
						st_d.sysc[S_DEEP] = pwdata[S_DEEP] &&
						    !(st_q.pmc1[P1_UVDE] && st_q.pmc1[P1_UVSE]);
					end
					if (wr && paddr == ADDR_WAKE) begin
						st_d.wake_ival = pwdata[5:0];
						st_d.wake_cnt  = 6'h00;
					end
					if (wr && paddr == ADDR_WAKE && pwdata[W_CLR])
						st_d.wake_flag = 1'b0;
					// interrupt mode; set wins over ack
					if (uv_set)
						st_d.pmc1[P1_UVIF] = 1'b1;
					// warning flag, set wins over ack
					if (!warn_ok)
						st_d.pmc3[P3_WF] = 1'b1;
					st_d.irq = st_d.pmc1[P1_UVIF] && st_d.pmc1[P1_UVIE] ||
					           evt_in.swi;
					if (evt_in.swi)
						st_d.vec = VEC_SWI;
					else if (st_d.pmc1[P1_UVIF] && st_d.pmc1[P1_UVIE])
						st_d.vec = VEC_UV;
					else
						st_d.vec = VEC_RESET;
				end
			end
			default: st_d.mode = RLVS_HOLD;
		endcase
		st_d.prdata = acc ? rd_mux(st_q, paddr) : 32'h0000_0000;
	end

	// ==========================================================
	// State register
	// power-on marks both cause bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			st_q.mode <= RLVS_HOLD;
			st_q.cause <= CAUSE_POR;
			st_q.pmc1 <= PMC1_RST;
			st_q.sys_reset <= 1'b1;
			st_q.vec <= VEC_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs, each straight from the state register
	assign prdata              = st_q.prdata;
	assign pready              = st_q.pready;
	assign pslverr             = st_q.pslverr;
	assign sys_reset           = st_q.sys_reset;
	assign irq_req             = st_q.irq;
	assign vector_addr         = st_q.vec;
	assign stop_active         = st_q.sysc[S_STOP];
	assign deep_stop_active    = st_q.sysc[S_DEEP];
	assign detector_on         = st_q.pmc1[P1_UVDE];
	assign trip_level_high     = st_q.pmc3[P3_UVV];
	assign warn_level_high     = st_q.pmc3[P3_WV];
	assign watchdog_clear      = st_q.wdclr;
	assign temp_restart_enable = st_q.sysc[S_TRE];

endmodule : rlvs_top
`default_nettype wire

/* File: shared/rlvs_pkg.sv */
// Package for the reset and low-voltage supervisor: map, fields, vectors
package rlvs_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] ADDR_CAUSE = 12'h000;
	localparam logic [11:0] ADDR_PMC1  = 12'h004;
	localparam logic [11:0] ADDR_PMC3  = 12'h008;
	localparam logic [11:0] ADDR_SYSC  = 12'h00C;
	localparam logic [11:0] ADDR_WAKE  = 12'h010;

	// ==========================================================
	// Field positions
	// Cause register: bit7 power-on .. bit1 undervolt, bit0 reserved
	localparam int C_POR  = 7;
	localparam int C_PIN  = 6;
	localparam int C_WDG  = 5;
	localparam int C_ILOP = 4;
	localparam int C_ILAD = 3;
	localparam int C_PWU  = 2;
	localparam int C_UV   = 1;
	// Control one
	localparam int P1_UVIF  = 7;
	localparam int P1_UVACK = 6;
	localparam int P1_UVIE  = 5;
	localparam int P1_UVRE  = 4;
	localparam int P1_UVSE  = 3;
	localparam int P1_UVDE  = 2;
	// Control three
	localparam int P3_WF    = 7;
	localparam int P3_WACK  = 6;
	localparam int P3_UVV   = 5;
	localparam int P3_WV    = 4;
	// System control
	localparam int S_WDGE = 0;
	localparam int S_TRE  = 1;
	localparam int S_STOP = 2;
	localparam int S_DEEP = 3;
	localparam int S_WDCK = 4;
	// Wake interval register
	localparam int W_CLR  = 7;

	// ==========================================================
	// Reset values and vectors
	localparam logic [7:0]  CAUSE_POR   = 8'h82;
	localparam logic [7:0]  PMC1_RST    = 8'h1C;
	localparam logic [15:0] VEC_RESET   = 16'hDFFE;
	localparam logic [15:0] VEC_SWI     = 16'hDFFC;
	localparam logic [15:0] VEC_UV      = 16'hDFF8;
	localparam logic [5:0]  WAKE_OFF    = 6'h00;

	typedef enum logic [1:0] {
		RLVS_RUN   = 2'b00,
		RLVS_RESET = 2'b01,
		RLVS_HOLD  = 2'b10
	} rlvs_mode_t;

	// Asynchronous comparator inputs
	typedef struct packed {
		logic por_ok;
		logic above_hi;
		logic above_lo;
		logic warn_hi;
		logic warn_lo;
		logic temp_cross;
	} rlvs_cmp_t;

	// CPU-side events, one-cycle pulses
	typedef struct packed {
		logic ill_op;
		logic ill_addr;
		logic swi;
		logic wdg_expire;
		logic wake_tick;
		logic ext_pin;
	} rlvs_evt_t;

endpackage : rlvs_pkg

/* File: tb/rlvs_supply_model.sv */
// Behavioural supply comparators and temperature detector
`timescale 1ns/100ps
`default_nettype none
module rlvs_supply_model #(
	parameter logic [7:0] POR_V = 8'h0A,
	parameter logic [7:0] LO_V  = 8'h14,
	parameter logic [7:0] HI_V  = 8'h1E,
	parameter logic [7:0] WLO_V = 8'h28,
	parameter logic [7:0] WHI_V = 8'h32
) (
	input  wire logic [7:0]          supply,
	input  wire logic                hot,
	output var  rlvs_pkg::rlvs_cmp_t cmp
);
	assign cmp = {supply > POR_V, supply > HI_V, supply > LO_V,
		supply > WHI_V, supply > WLO_V, hot};
endmodule : rlvs_supply_model
`default_nettype wire

/* File: tb/rlvs_props.sv */
// Port-level properties of the supervisor
`timescale 1ns/100ps
`default_nettype none
module rlvs_props (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire rlvs_pkg::rlvs_cmp_t cmp_in,
	input wire rlvs_pkg::rlvs_evt_t evt_in,
	input wire logic                sys_reset,
	input wire logic                irq_req,
	input wire logic [15:0]         vector_addr,
	input wire logic                deep_stop_active,
	input wire logic                watchdog_clear,
	input wire logic                temp_restart_enable
);
	import rlvs_pkg::*;
	// ==========================================================
	// Helpers
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic taken;
	assign taken = psel && penable && !pready;
	// ==========================================================
	// Properties
	a_ready_next: assert property (taken |=> pready) else $error("no ready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_err_zero:
		assert property (pslverr |-> pready && prdata == 32'h0) else $error("err");
	a_illop_reset:
		assert property (evt_in.ill_op && !sys_reset |-> ##[1:2]
			sys_reset && vector_addr == VEC_RESET) else $error("ill op");
	a_illad_reset:
		assert property (evt_in.ill_addr && !sys_reset |-> ##[1:2]
			sys_reset && vector_addr == VEC_RESET) else $error("ill addr");
	a_swi_vector:
		assert property (evt_in.swi && !sys_reset && !irq_req &&
			!deep_stop_active |-> ##[1:2]
			irq_req && vector_addr == VEC_SWI) else $error("swi");
	a_wdg_clear:
		assert property (taken && pwrite && paddr == ADDR_CAUSE && !sys_reset
			|-> ##[1:2] watchdog_clear) else $error("wdg clear");
	a_temp_reset:
		assert property (cmp_in.temp_cross && temp_restart_enable && !sys_reset
			|-> ##[1:5] sys_reset) else $error("temp");
	a_hold_release:
		assert property ($fell(sys_reset) |-> $past(cmp_in.above_lo, 3))
			else $error("early release");
	// Hit checks on the main scenarios
	c_err: cover property (pslverr);
	c_uv: cover property (irq_req && vector_addr == VEC_UV);
	c_src: cover property (evt_in.ill_op ##[1:2] sys_reset);
endmodule : rlvs_props
bind rlvs_top rlvs_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .cmp_in, .evt_in, .sys_reset,
	.irq_req, .vector_addr, .deep_stop_active, .watchdog_clear,
	.temp_restart_enable);
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import rlvs_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hot = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, d;
	logic [7:0] supply = 8'h0F;
	rlvs_evt_t evt_in = '0;
	rlvs_cmp_t cmp_in;
	logic pready, pslverr, sys_reset, irq_req, stop_active, deep_stop_active;
	logic detector_on, trip_level_high, warn_level_high, watchdog_clear;
	logic temp_restart_enable, err;
	logic [15:0] vector_addr;
	int bad_count = 0, total_checks = 0, seed = 32'hF89F;
	logic [5:0] masks [6] = '{6'h20, 6'h10, 6'h04, 6'h02, 6'h01, 6'h30};
	always #50 pclk = ~pclk;
	rlvs_top u_rlvs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cmp_in, .evt_in, .sys_reset,
		.irq_req, .vector_addr, .stop_active, .deep_stop_active, .detector_on,
		.trip_level_high, .warn_level_high, .watchdog_clear,
		.temp_restart_enable);
	rlvs_supply_model u_rlvs_supply_model (.supply, .hot, .cmp(cmp_in));
	function automatic logic [31:0] cause_of(input logic [5:0] m);
		return {24'h0, 1'b0, m[0], m[2], m[5], m[4], m[1], 2'b00};
	endfunction : cause_of
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic w(input logic [11:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask : w
	task automatic r(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : r
	task automatic pulse(input logic [5:0] m);
		@(posedge pclk);
		evt_in <= m;
		@(posedge pclk);
		evt_in <= '0;
	endtask : pulse
	// Bounded waits: reset must show, then clear again
	task automatic wait_run;
		for (int n = 0; n < 9 && sys_reset !== 1'b1; n++) @(posedge pclk);
		chk(sys_reset, 1'b1);
		for (int n = 0; n < 40 && sys_reset !== 1'b0; n++) @(posedge pclk);
		chk(sys_reset, 1'b0);
	endtask : wait_run
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	initial begin
		#1000000;
		bad_count++;
		close_out;
	end
	initial begin
		cyc(6);
		chk(vector_addr, VEC_RESET);
		presetn <= 1'b1;
		r(ADDR_CAUSE, 32'h82);
		r(ADDR_PMC1, 32'h1C);
		chk(sys_reset, 1'b1);
		supply <= 8'h3C;
		wait_run;
		w(ADDR_CAUSE, 32'hFF);
		chk(watchdog_clear, 1'b1);
		r(ADDR_CAUSE, 32'h82);
		chk(watchdog_clear, 1'b0);
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			apb(1'b0, d[11:0] & 12'h01C, 32'h0);
			chk(err, (d[11:0] & 12'h01C) > ADDR_WAKE);
			w(ADDR_PMC3, d);
			cyc(2);
			chk({trip_level_high, warn_level_high}, d[5:4]);
			r(ADDR_PMC3, d & 32'h30);
		end
		w(ADDR_PMC3, 32'h0);
		supply <= 8'h23;
		cyc(6);
		r(ADDR_PMC3, 32'h80);
		w(ADDR_PMC3, 32'h40);
		r(ADDR_PMC3, 32'h80);
		chk(irq_req, 1'b0);
		supply <= 8'h3C;
		cyc(6);
		w(ADDR_PMC3, 32'h40);
		r(ADDR_PMC3, 32'h0);
		w(ADDR_PMC1, 32'h24);
		supply <= 8'h0F;
		cyc(6);
		chk({irq_req, vector_addr}, {1'b1, VEC_UV});
		r(ADDR_PMC1, 32'hA4);
		supply <= 8'h3C;
		cyc(4);
		w(ADDR_PMC1, 32'h64);
		r(ADDR_PMC1, 32'h24);
		w(ADDR_PMC1, 32'h0);
		supply <= 8'h0F;
		cyc(6);
		chk({sys_reset, irq_req}, 2'b00);
		supply <= 8'h3C;
		pulse(6'h08);
		w(ADDR_PMC1, 32'h1C);
		w(ADDR_SYSC, 32'h08);
		cyc(2);
		chk(deep_stop_active, 1'b0);
		w(ADDR_PMC1, 32'h14);
		w(ADDR_SYSC, 32'h04);
		cyc(2);
		chk({stop_active, detector_on}, 2'b11);
		supply <= 8'h0F;
		cyc(6);
		chk(sys_reset, 1'b0);
		supply <= 8'h3C;
		cyc(4);
		w(ADDR_SYSC, 32'h08);
		cyc(2);
		chk(deep_stop_active, 1'b1);
		pulse(6'h08);
		wait_run;
		chk(vector_addr, VEC_RESET);
		r(ADDR_CAUSE, 32'h0);
		for (int i = 0; i < 6; i++) begin
			w(ADDR_SYSC, 32'h01);
			w(ADDR_WAKE, 32'h01);
			pulse(masks[i]);
			wait_run;
			r(ADDR_CAUSE, cause_of(masks[i]));
		end
		w(ADDR_WAKE, 32'h03);
		pulse(6'h02);
		pulse(6'h02);
		cyc(2);
		chk(sys_reset, 1'b0);
		pulse(6'h02);
		wait_run;
		r(ADDR_WAKE, 32'h40);
		pulse(6'h04);
		cyc(4);
		chk(sys_reset, 1'b0);
		w(ADDR_SYSC, 32'h02);
		cyc(2);
		chk(temp_restart_enable, 1'b1);
		hot <= 1'b1;
		wait_run;
		hot <= 1'b0;
		supply <= 8'h0F;
		cyc(10);
		r(ADDR_CAUSE, 32'h82);
		chk(sys_reset, 1'b1);
		supply <= 8'h3C;
		wait_run;
		close_out;
	end
endmodule : testbench
`default_nettype wire
